// >>> hdl/relay_pkg.sv
// package of constants and types for the threshold relay control block
// assumes a 200 MHz system clock and a 32-bit signed counter result
// Function
// RULE1 - relay may go active only while result is at or above threshold
// RULE2 - active contact form, closed or open, comes from the relay mode
// RULE3 - primary relay follows the result with no qualification delay
// RULE4 - other relays need the result at threshold for 20 ms continuously
// RULE5 - first-threshold auto zero reloads the counter with the preload
// RULE6 - below-zero auto zero reloads primary threshold plus preload minus 1
// RULE7 - under auto zero, other thresholds must be within primary or nonnegative
// RULE8 - output switches within 15 ms (open collector) or 20 ms (relay)
// RULE9 - software keeps preload and primary threshold consistent for auto zero
// RULE10 - zero hold time keeps relay active while result stays at threshold
// RULE11 - nonzero hold time keeps relay active for the programmed duration
// RULE12 - reaching threshold again during a hold restarts the full hold
// RULE13 - bus driven relays follow only their holding register writes
// RULE14 - in closed/open modes holding writes ignored, reads give real state
// RULE15 - bus driven relays come up inactive after power up
// RULE16 - disabled relay stays permanently off
// RULE17 - hold time 0.1 to 99.9 in tenths, seconds or minutes
// RULE18 - thresholds are signed, range -99999 to 999999
// RULE19 - timing from a system clock tick; reset clears timers, relays off
package relay_pkg;

    localparam int          NUM_RELAYS     = 4;
    localparam int          COUNT_W        = 32;
    localparam int          THR_W          = 21;
    localparam int          HOLD_W         = 10;
    localparam int          HOLD_MS_W      = 24;

    // timing
    localparam int          CLK_HZ         = 200_000_000;
    localparam int          MS_TICK_NS     = 1_000_000;
    localparam int          MS_TICK_CYC    = MS_TICK_NS / 5;
    localparam int          QUAL_MS        = 20;
    // one extra tick, since the first millisecond tick may come early
    localparam int          QUAL_TICKS     = QUAL_MS + 1;
    localparam int          OC_SWITCH_MS   = 15;
    localparam int          MS_PER_TENTH_S = 100;
    localparam int          MS_PER_TENTH_M = 6000;
    localparam int          HOLD_MAX       = 999;

    // register byte offsets
    localparam logic [7:0]  AUTO_ZERO_OFS  = 8'h00;
    localparam logic [7:0]  PRELOAD_OFS    = 8'h04;
    localparam logic [7:0]  STATUS_OFS     = 8'h08;
    localparam logic [7:0]  RELAY_BASE_OFS = 8'h10;
    localparam logic [7:0]  RELAY_STRIDE   = 8'h10;
    localparam logic [3:0]  THRESH_SUB     = 4'h0;
    localparam logic [3:0]  CONFIG_SUB     = 4'h4;
    localparam logic [3:0]  HOLDING_SUB    = 4'h8;

    // config field positions
    localparam int          CFG_HOLD_LSB   = 0;
    localparam int          CFG_UNIT_BIT   = 12;
    localparam int          CFG_MODE_LSB   = 16;

    // reset values
    localparam logic [THR_W-1:0]   THRESH_RST  = 21'h000000;
    localparam logic [COUNT_W-1:0] PRELOAD_RST = 32'h00000000;

    typedef enum logic [1:0] {
        relay_disabled = 2'h0,
        closed_active  = 2'h1,
        open_active    = 2'h2,
        bus_driven     = 2'h3
    } relay_mode_type;

    typedef enum logic [1:0] {
        zero_off                = 2'h0,
        zero_at_first_threshold = 2'h1,
        zero_below_zero         = 2'h2
    } auto_zero_type;

    typedef struct packed {
        relay_mode_type     mode;
        logic               minutes;
        logic [HOLD_W-1:0]  hold;
    } relay_cfg_type;

    localparam relay_cfg_type CFG_RST = '{relay_disabled, 1'b0, 10'h000};

    typedef struct packed {
        logic               reload;
        logic [COUNT_W-1:0] value;
    } reload_req_type;

endpackage

// >>> hdl/relay_timer.sv
// one relay's qualification and hold timing
// assumes ms_tick is a one-cycle pulse once per millisecond on sys_clk
`timescale 1ns/1ps
module relay_timer #(
    parameter bit                   PRIMARY = 1'b0
) (
    input  wire logic                              sys_clk,
    input  wire logic                              sys_rst,
    input  wire logic                              ms_tick,
    input  wire logic                              at_threshold,
    input  wire logic [relay_pkg::HOLD_MS_W-1:0]   hold_ms,
    output logic                                   active
);
    import relay_pkg::*;

    logic [4:0]           qual_r;
    logic [4:0]           qual_nxt;
    logic                 met_r;
    logic [HOLD_MS_W-1:0] remain_r;
    logic [HOLD_MS_W-1:0] remain_nxt;
    wire                  met_now;
    wire                  rise;

    // qualification counter saturates once 20 ms are seen
    assign qual_nxt = !at_threshold ? 5'h00 :
                      (ms_tick && qual_r != 5'(QUAL_TICKS)) ?
                      qual_r + 5'h01 : qual_r; // RULE4
    assign met_now  = PRIMARY ? at_threshold
                              : (qual_r == 5'(QUAL_TICKS)); // RULE3 RULE4
    assign rise     = met_now & ~met_r;

    // a new crossing reloads the full hold, else count it down
    assign remain_nxt = rise ? hold_ms : // RULE12
                        (ms_tick && remain_r != '0) ?
                        remain_r - HOLD_MS_W'(1) : remain_r; // RULE11

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            qual_r   <= 5'h00; // RULE19
            met_r    <= 1'b0;
            remain_r <= '0;
        end else begin
            qual_r   <= qual_nxt;
            met_r    <= met_now;
            remain_r <= remain_nxt;
        end
    end

    // zero hold follows the registered comparison, one cycle late
    assign active = (hold_ms == '0) ? met_r : (remain_r != '0); // RULE10 RULE1

endmodule // relay_timer

// >>> hdl/threshold_relay_control.sv
// threshold comparison and relay output control with an Avalon-MM slave
// assumes count_value comes from counter logic on sys_clk, the counter
// takes reload_req in the cycle it is presented, and relay pins are
// driven through external open collector or coil drivers
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module threshold_relay_control #(
    parameter int MS_TICK_CYCLES = relay_pkg::MS_TICK_CYC
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 sys_rst,
    // counter result and reload
    input  wire logic signed [relay_pkg::COUNT_W-1:0] count_value,
    output relay_pkg::reload_req_type                 reload_req,
    // relay drive and indicators, 1 = contact closed
    output logic [relay_pkg::NUM_RELAYS-1:0]          relay_closed,
    output logic [relay_pkg::NUM_RELAYS-1:0]          relay_led,
    // Avalon-MM slave
    input  wire logic [7:0]                           avs_address,
    input  wire logic                                 avs_read,
    input  wire logic                                 avs_write,
    input  wire logic [31:0]                          avs_writedata,
    input  wire logic [3:0]                           avs_byteenable,
    output logic [31:0]                               avs_readdata,
    output logic                                      avs_waitrequest
);
    import relay_pkg::*;

    localparam int N = NUM_RELAYS;

    // ---------------- register state ----------------
    logic [1:0]                 auto_zero_r;
    logic signed [COUNT_W-1:0]  preload_r;
    logic signed [THR_W-1:0]    thresh_r [N];
    relay_cfg_type              cfg_r    [N];
    logic [N-1:0]               holding_r;
    logic [N-1:0]               closed_r;
    logic                       ack_r;
    logic [31:0]                rdata_r;
    logic [31:0]                rdata_nxt;
    reload_req_type             reload_r;
    logic [31:0]                tick_cnt_r;
    logic                       ms_tick_r;

    // ---------------- bus decode ----------------
    wire        access    = avs_read | avs_write;
    wire        wr_take   = avs_write & ack_r; // lands as waitrequest drops
    wire        hit_az    = (avs_address == AUTO_ZERO_OFS);
    wire        hit_pre   = (avs_address == PRELOAD_OFS);
    wire        hit_stat  = (avs_address == STATUS_OFS);
    wire [7:0]  rel_off   = avs_address - RELAY_BASE_OFS;
    wire [3:0]  rel_idx   = rel_off[7:4];
    wire [3:0]  rel_sub   = rel_off[3:0];
    wire        rel_hit   = (avs_address >= RELAY_BASE_OFS) &&
                            (rel_idx < 4'(N));
    wire [31:0] wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // each request waits exactly one cycle, then completes
    assign avs_waitrequest = access & ~ack_r;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r   <= access & ~ack_r;
            rdata_r <= (avs_read & ~ack_r) ? rdata_nxt : rdata_r;
        end
    end

    // ---------------- millisecond tick ----------------
    // one shared divider; per relay timers only count ticks
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tick_cnt_r <= 32'h00000000; // RULE19
            ms_tick_r  <= 1'b0;
        end else if (tick_cnt_r == 32'(MS_TICK_CYCLES - 1)) begin
            tick_cnt_r <= 32'h00000000;
            ms_tick_r  <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
            ms_tick_r  <= 1'b0;
        end
    end

    // ---------------- global registers ----------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            auto_zero_r <= 2'h0;
            preload_r   <= PRELOAD_RST;
        end else if (wr_take) begin
            if (hit_az && avs_byteenable[0])
                auto_zero_r <= avs_writedata[1:0];
            if (hit_pre)
                preload_r <= (preload_r & ~wmask) | (avs_writedata & wmask);
        end
    end

    // ---------------- auto zero ----------------
    wire signed [COUNT_W-1:0] thr1 = COUNT_W'(thresh_r[0]);
    wire zero_first = (auto_zero_r == zero_at_first_threshold);
    wire zero_below = (auto_zero_r == zero_below_zero);
    wire hit_first  = zero_first && (count_value >= thr1); // RULE5
    wire hit_below  = zero_below && (count_value < 0); // RULE6
    wire signed [COUNT_W-1:0] below_value = thr1 + preload_r
                                          - COUNT_W'(1); // RULE6

    // reload is one cycle; the counter has not moved by the next compare,
    // so back-to-back pulses are suppressed rather than repeated
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reload_r <= '0;
        end else begin
            reload_r.reload <= (hit_first | hit_below) & ~reload_r.reload;
            reload_r.value  <= hit_first ? preload_r : below_value; // RULE5
        end
    end
    assign reload_req = reload_r;

    // ---------------- per relay channels ----------------
    logic [N-1:0]  timer_active;
    logic [31:0]   rel_rdata [N];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : chan
            wire signed [COUNT_W-1:0] thr = COUNT_W'(thresh_r[g]);
            wire sel = wr_take && rel_hit && (rel_idx == 4'(g));
            // under auto zero, other relays only within the auto zero window
            wire allowed = (g == 0) ? 1'b1 :
                           zero_first ? (thr <= thr1) :
                           zero_below ? (thr >= 0) : 1'b1; // RULE7
            wire at_thr = allowed && (count_value >= thr); // RULE1
            wire [HOLD_MS_W-1:0] hold_ms = HOLD_MS_W'(cfg_r[g].hold) *
                (cfg_r[g].minutes ? HOLD_MS_W'(MS_PER_TENTH_M)
                                  : HOLD_MS_W'(MS_PER_TENTH_S)); // RULE17
            wire is_bus = (cfg_r[g].mode == bus_driven);
            wire phys;

            // threshold and config writes
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    thresh_r[g] <= THRESH_RST;
                    cfg_r[g]    <= CFG_RST;
                end else if (sel && rel_sub == THRESH_SUB) begin
                    thresh_r[g] <= avs_writedata[THR_W-1:0]; // RULE18
                end else if (sel && rel_sub == CONFIG_SUB) begin
                    cfg_r[g].hold    <= (avs_writedata[9:0] > 10'(HOLD_MAX))
                                        ? 10'(HOLD_MAX)
                                        : avs_writedata[9:0]; // RULE17
                    cfg_r[g].minutes <= avs_writedata[CFG_UNIT_BIT];
                    cfg_r[g].mode    <= relay_mode_type'(
                        avs_writedata[CFG_MODE_LSB+1:CFG_MODE_LSB]);
                end
            end

            // holding register only accepts writes in bus mode
            always_ff @(posedge sys_clk) begin
                if (sys_rst)
                    holding_r[g] <= 1'b0; // RULE15
                else if (sel && rel_sub == HOLDING_SUB && is_bus)
                    holding_r[g] <= avs_writedata[0]; // RULE13 RULE14
            end

            relay_timer #(
                .PRIMARY      (g == 0)
            ) u_timer (
                .sys_clk      (sys_clk),
                .sys_rst      (sys_rst),
                .ms_tick      (ms_tick_r),
                .at_threshold (at_thr),
                .hold_ms      (hold_ms),
                .active       (timer_active[g])
            );

            // contact form from mode
            assign phys =
                (cfg_r[g].mode == closed_active) ?  timer_active[g] :
                (cfg_r[g].mode == open_active)   ? ~timer_active[g] :
                is_bus ? holding_r[g] : 1'b0; // RULE2 RULE13 RULE16

            // registered drive, so output lags the compare by two cycles,
            // far inside the 15 ms switching budget
            always_ff @(posedge sys_clk) begin
                if (sys_rst)
                    closed_r[g] <= 1'b0; // RULE19
                else
                    closed_r[g] <= phys; // RULE8
            end

            // read mux per relay; holding reads show the real contact
            assign rel_rdata[g] =
                (rel_sub == THRESH_SUB) ? 32'(thresh_r[g]) :
                (rel_sub == CONFIG_SUB) ?
                    {14'h0000, cfg_r[g].mode, 3'h0, cfg_r[g].minutes,
                     2'h0, cfg_r[g].hold} :
                (rel_sub == HOLDING_SUB) ?
                    {31'h00000000, is_bus ? holding_r[g]
                                          : closed_r[g]} // RULE14
                    : 32'h00000000;
        end
    endgenerate

    // ---------------- read data select ----------------
    // unmapped offsets read as zero and ignore writes
    assign rdata_nxt =
        hit_az   ? {30'h00000000, auto_zero_r} :
        hit_pre  ? preload_r :
        hit_stat ? {{(32-N){1'b0}}, closed_r} :
        (rel_hit && (rel_sub == THRESH_SUB || rel_sub == CONFIG_SUB ||
                     rel_sub == HOLDING_SUB)) ? rel_rdata[rel_idx[1:0]] :
        32'h00000000;

    assign relay_closed = closed_r;
    assign relay_led    = closed_r; // led lit means contact closed

endmodule // threshold_relay_control

// >>> verif/pulse_counter_model.sv
// behavioural pulse counter on the far side of the relay block
// assumes reload requests are one-cycle pulses on sys_clk
`timescale 1ns/1ps
module pulse_counter_model (
    input  wire logic                         sys_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         set_en,
    input  wire logic signed [31:0]           set_val,
    input  wire relay_pkg::reload_req_type    reload_req,
    output logic signed [31:0]                count_value
);
    // a reload beats a preset, as the real counter zeroes at once
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_value <= '0;
        end else if (reload_req.reload) begin
            count_value <= reload_req.value;
        end else if (set_en) begin
            count_value <= set_val;
        end
    end
endmodule // pulse_counter_model

// >>> verif/relay_chk.sv
// port checker for the relay control block
// assumes it is bound into every threshold_relay_control instance
`timescale 1ns/1ps
module relay_chk
    import relay_pkg::*;
#(
    parameter int MS_TICK_CYCLES = relay_pkg::MS_TICK_CYC
) (
    input wire logic                          sys_clk,
    input wire logic                          sys_rst,
    input wire logic signed [31:0]            count_value,
    input wire relay_pkg::reload_req_type     reload_req,
    input wire logic [3:0]                    relay_closed,
    input wire logic [3:0]                    relay_led,
    input wire logic [7:0]                    avs_address,
    input wire logic                          avs_read,
    input wire logic                          avs_write,
    input wire logic [31:0]                   avs_writedata,
    input wire logic [3:0]                    avs_byteenable,
    input wire logic [31:0]                   avs_readdata,
    input wire logic                          avs_waitrequest
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // a request starts when read or write rises out of idle
    sequence s_req_start;
        (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    // reset checks stay live during reset, so no disable there
    chk_reset_relays_off: assert property (
        disable iff (1'b0) sys_rst |=> relay_closed == '0 && !reload_req.reload)
        else $error("relays or reload not cleared by reset");
    chk_led_follows_relay: assert property (
        relay_led == relay_closed)
        else $error("indicator differs from relay contact");
    chk_reload_one_pulse: assert property (
        reload_req.reload |=> !reload_req.reload)
        else $error("reload pulse longer than one cycle");
    chk_bus_one_wait: assert property (
        s_req_start |-> s_one_wait)
        else $error("bus answer not after exactly one wait");
    chk_idle_no_wait: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    // sys_rst in the antecedent keeps a reset clear from looking like a slip
    chk_readdata_stands: assert property (
        !avs_read && !sys_rst |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    chk_status_mirror: assert property (
        avs_read && !avs_waitrequest && avs_address == STATUS_OFS
        && $stable(relay_closed) |-> avs_readdata[3:0] == relay_closed)
        else $error("status read differs from relay contacts");
    chk_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 8'h0C
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // relay_chk

bind threshold_relay_control relay_chk #(
    .MS_TICK_CYCLES(MS_TICK_CYCLES)
) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .count_value(count_value),
    .reload_req(reload_req), .relay_closed(relay_closed),
    .relay_led(relay_led), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
);

// >>> verif/test_threshold_relay_control.sv
// self-checking bench for the relay block with a counter model
// assumes a 10-cycle millisecond tick to keep the run short
`timescale 1ns/1ps
module test_threshold_relay_control;
    import relay_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic signed [31:0]    count_value;
    reload_req_type        reload_req;
    logic [3:0]            relay_closed;
    logic [3:0]            relay_led;
    logic [7:0]            avs_address = 8'h00;
    logic                  avs_read = 1'b0;
    logic                  avs_write = 1'b0;
    logic [31:0]           avs_writedata = 32'h0;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic                  set_en = 1'b0;
    logic signed [31:0]    set_val = '0;
    logic [31:0]           rd;
    int                    num_errors = 0;
    int                    checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    threshold_relay_control #(.MS_TICK_CYCLES(10)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .count_value(count_value),
        .reload_req(reload_req), .relay_closed(relay_closed),
        .relay_led(relay_led), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    pulse_counter_model u_cnt (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .set_en(set_en),
        .set_val(set_val), .reload_req(reload_req),
        .count_value(count_value));

    task automatic end_of_test;
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] ra(input logic [7:0] n,
                                      input logic [3:0] sub);
        return RELAY_BASE_OFS + RELAY_STRIDE * n + {4'h0, sub};
    endfunction
    // one Avalon transfer; the request holds until waitrequest is low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        // waitrequest and read data are seen as they stand at the edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check("bus answer", 32'h1, {31'h0, n < 100});
    endtask
    task automatic set_count(input logic signed [31:0] v);
        @(posedge sys_clk);
        set_en <= 1'b1;
        set_val <= v;
        @(posedge sys_clk);
        set_en <= 1'b0;
    endtask
    // sample mid-cycle so edge updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic t_reset_values;
        bus(0, ra(8'h0, CONFIG_SUB), 32'h0);
        check("config reset", 32'h0, rd);
        bus(0, AUTO_ZERO_OFS, 32'h0);
        check("auto zero reset", 32'h0, rd);
        bus(0, 8'h0C, 32'h0);
        check("unmapped read", 32'h0, rd);
    endtask
    task automatic t_primary_and_qual;
        bus(1, ra(8'h0, THRESH_SUB), 32'd100);
        bus(1, ra(8'h0, CONFIG_SUB), 32'h00010000);
        bus(1, ra(8'h1, THRESH_SUB), 32'd100);
        bus(1, ra(8'h1, CONFIG_SUB), 32'h00020000);
        set_count(99);
        cyc(4);
        check("below threshold", 32'h2, {28'h0, relay_closed});
        set_count(100);
        cyc(2);
        check("primary on", 32'h1, {31'h0, relay_closed[0]});
        cyc(150);
        check("second waits", 32'h1, {31'h0, relay_closed[1]});
        cyc(90);
        check("second opens", 32'h0, {31'h0, relay_closed[1]});
        set_count(50);
        cyc(2);
        check("primary off", 32'h0, {31'h0, relay_closed[0]});
    endtask
    task automatic t_hold;
        bus(1, ra(8'h0, CONFIG_SUB), 32'h00010001);
        set_count(100);
        set_count(0);
        cyc(500);
        check("held", 32'h1, {31'h0, relay_closed[0]});
        set_count(100);
        set_count(0);
        cyc(800);
        check("extended", 32'h1, {31'h0, relay_closed[0]});
        cyc(400);
        check("hold over", 32'h0, {31'h0, relay_closed[0]});
    endtask
    task automatic t_auto_zero;
        bus(1, PRELOAD_OFS, 32'd5);
        bus(1, AUTO_ZERO_OFS, 32'h1);
        set_count(100);
        cyc(3);
        check("first reload", 32'd5, count_value);
        bus(1, AUTO_ZERO_OFS, 32'h2);
        set_count(-1);
        cyc(3);
        check("below reload", 32'd104, count_value);
        bus(1, AUTO_ZERO_OFS, 32'h0);
    endtask
    task automatic t_bus_mode;
        bus(1, ra(8'h0, CONFIG_SUB), 32'h0);
        bus(1, ra(8'h1, CONFIG_SUB), 32'h00030000);
        bus(1, ra(8'h1, HOLDING_SUB), 32'h1);
        set_count(-50);
        cyc(3);
        check("bus relay", 32'h1, {31'h0, relay_closed[1]});
        bus(1, ra(8'h2, THRESH_SUB), 32'd1000);
        bus(1, ra(8'h2, CONFIG_SUB), 32'h00010000);
        bus(1, ra(8'h2, HOLDING_SUB), 32'h1);
        bus(0, ra(8'h2, HOLDING_SUB), 32'h0);
        check("holding ignored", 32'h0, rd);
        bus(1, ra(8'h3, THRESH_SUB), 32'hFFFE7961);
        bus(0, ra(8'h3, THRESH_SUB), 32'h0);
        check("negative thr", 32'hFFFE7961, rd);
        bus(1, ra(8'h3, CONFIG_SUB), 32'h000013E8);
        bus(0, ra(8'h3, CONFIG_SUB), 32'h0);
        check("hold clamp", 32'h000013E7, rd);
        bus(0, STATUS_OFS, 32'h0);
        check("status", 32'h2, rd);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cyc(1);
        check("after reset", 32'h0, {28'h0, relay_closed});
        // back in bus mode the holding bit must have come up cleared
        bus(1, ra(8'h1, CONFIG_SUB), 32'h00030000);
        bus(0, ra(8'h1, HOLDING_SUB), 32'h0);
        check("bus holding reset", 32'h0, rd);
        cyc(1);
        check("bus relay reset", 32'h0, {31'h0, relay_closed[1]});
    endtask

    // cuts a hang far beyond the roughly 2100 cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_primary_and_qual();
        t_hold();
        t_auto_zero();
        t_bus_mode();
        end_of_test();
    end
endmodule // test_threshold_relay_control
